// file: rtl/ticap_top.sv
// Timer pair with input capture unit behind an APB slave
`timescale 1ns/100ps
`include "ticap_regs.svh"
//Contract
// - Control bit 1 of the first timer control picks the count source.
// - Source bit zero: timer advances once per instruction cycle.
// - Source bit one: timer advances on external or oscillator rising edge.
// - Oscillator enable forces both oscillator pins to inputs reading zero.
// - Timer has a synchronous clear input, tied low at both timer instances.
// - Capture copies the selected sixteen-bit timer count into the pair.
// - Mode field selects falling, rising, every 4th or 16th rising edge.
// - Each capture sets the flag; only software clears it.
// - A newer capture overwrites an unread captured value.
// - Edge detector watches the pin level, so output writes can capture.
// - Second timer control bit 6 chooses which timer feeds capture.
// - Changing capture mode may spuriously set the flag.
// - Prescaler counter clears when the unit is off or not capturing.
// - Direct prescale change keeps the counter and may set the flag.
module ticap_top (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port pins 0 to 2
   input wire logic [2:0] port_in,
   output logic [2:0] port_out,
   output logic [2:0] port_oe,
   // Capture status towards the core
   output logic capture_event_irq,
   output ticap_pkg::ticap_count_t capture_value_pair
);
   import ticap_pkg::*;

   logic [7:0] first_timer_control_q;
   logic [7:0] second_timer_control_q;
   logic [7:0] capture_control_q;
   logic [7:0] peripheral_flags_a_q;
   logic [7:0] peripheral_irq_enables_a_q;
   logic [7:0] port_c_direction_q;
   logic [7:0] port_latch_q;
   ticap_count_t capture_value_pair_q;
   logic [3:0] prescale_q;
   logic [1:0] insn_div_q;
   logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
   logic [2:0] pin_lvl_q;
   logic capture_pin_prev_q;
   logic oscin_prev_q;

   logic wr_acc, rd_acc;
   logic count_source_select, low_freq_osc_enable;
   logic insn_tick, ext_rise, oscin_rise;
   logic cap_rise, cap_fall, cap_edge, cap_fire;
   logic cap_active, mode_change;
   logic capture_pin_lvl;
   logic [2:0] pin_mux;
   ticap_event_t ev_mode;
   ticap_count_t first_timer_count, second_timer_count, cap_src;
   logic [7:0] new_ctl;
   logic t1cnt_wr, t2cnt_wr, capctl_wr;
   logic first_on, second_on, cap_from_second, flag_set;
   logic [2:0] port_rd;
   logic [31:0] rd_mux;

   // Capture modes 4 to 7; any other value is off or not capturing
   function automatic logic is_capture(input logic [3:0] m);
      is_capture = (m[3:2] == 2'b01);
   endfunction

   // Low two mode bits pick the qualifying edge
   function automatic ticap_event_t ev_of(input logic [3:0] m);
      case (m[1:0])
         2'b00: ev_of = TICAP_EV_FALL;
         2'b01: ev_of = TICAP_EV_RISE;
         2'b10: ev_of = TICAP_EV_RISE4;
         default: ev_of = TICAP_EV_RISE16;
      endcase
   endfunction

   // Write strobe for one register offset, valid in the access cycle
   function automatic logic hit(input logic [11:0] off);
      hit = wr_acc && (paddr == off);
   endfunction

   // Strobes that feed ports and wires are made in a process, which
   // follows the bus; a bare call with a constant argument would not
   always_comb begin
      t1cnt_wr = hit(`TICAP_OFF_T1CNT);
      t2cnt_wr = hit(`TICAP_OFF_T2CNT);
      capctl_wr = hit(`TICAP_OFF_CAPCTL);
   end

   // APB answers in the access cycle, no wait states
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;
   assign new_ctl = pwdata[7:0];

   assign count_source_select =
      first_timer_control_q[`TICAP_BIT_SRC_SEL];
   assign low_freq_osc_enable = first_timer_control_q[`TICAP_BIT_OSC_EN];
   assign first_on = first_timer_control_q[`TICAP_BIT_TMR_ON];
   assign second_on = second_timer_control_q[`TICAP_BIT_TMR_ON];
   assign cap_from_second =
      second_timer_control_q[`TICAP_BIT_CAP_TMR2];

   // Timer controls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_timer_control_q <= `TICAP_RST_CTL;
         second_timer_control_q <= `TICAP_RST_CTL;
      end else begin
         if (hit(`TICAP_OFF_T1CTL)) first_timer_control_q <= new_ctl;
         if (hit(`TICAP_OFF_T2CTL)) second_timer_control_q <= new_ctl;
      end
   end

   // Capture control and interrupt enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_control_q <= `TICAP_RST_CTL;
         peripheral_irq_enables_a_q <= `TICAP_RST_CTL;
      end else begin
         if (capctl_wr) capture_control_q <= new_ctl;
         if (hit(`TICAP_OFF_IRQEN)) peripheral_irq_enables_a_q <= new_ctl;
      end
   end

   // Direction resets to all inputs so nothing is driven at power-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_c_direction_q <= `TICAP_RST_DIR;
         port_latch_q <= `TICAP_RST_PORT;
      end else begin
         if (hit(`TICAP_OFF_DIR)) port_c_direction_q <= new_ctl;
         if (hit(`TICAP_OFF_PORTOUT)) port_latch_q <= new_ctl;
      end
   end

   // Instruction cycle is four system clocks
   // Free running, so the tick phase does not depend on bus traffic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         insn_div_q <= 2'b00;
      end else begin
         insn_div_q <= insn_div_q + 2'b01;
      end
   end
   assign insn_tick = (insn_div_q == 2'(`TICAP_INSN_DIV - 1));

   // Three-stage synchroniser on the pins
   // A level counts only once the second and third stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
         pin_s3_q <= 3'h0;
         pin_lvl_q <= 3'h0;
      end else begin
         pin_s1_q <= pin_mux;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         for (int i = 0; i < 3; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) pin_lvl_q[i] <= pin_s3_q[i];
         end
      end
   end

   // Pin level is what the capture sees, own drive included
   generate
      for (genvar g = 0; g < 3; g++) begin : g_pin
         assign pin_mux[g] = port_oe[g] ? port_out[g] : port_in[g];
         assign port_out[g] = port_latch_q[g];
         if (g < 2) begin : g_osc
            assign port_oe[g] = !port_c_direction_q[g] &&
               !low_freq_osc_enable;
         end else begin : g_cap
            assign port_oe[g] = !port_c_direction_q[g];
         end
      end
   endgenerate

   assign capture_pin_lvl = pin_lvl_q[`TICAP_BIT_CAP_PIN];

   // Edge detection on filtered levels; reset low like the idle pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_pin_prev_q <= 1'b0;
      end else begin
         capture_pin_prev_q <= capture_pin_lvl;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oscin_prev_q <= 1'b0;
      end else begin
         oscin_prev_q <= pin_lvl_q[0];
      end
   end
   assign cap_rise = capture_pin_lvl && !capture_pin_prev_q;
   assign cap_fall = !capture_pin_lvl && capture_pin_prev_q;
   // Oscillator and external clock share pin 0 in this model
   assign oscin_rise = pin_lvl_q[0] && !oscin_prev_q;
   assign ext_rise = oscin_rise;

   // Both timers share the instruction tick and the pin 0 edges
   // Capture mode never restarts a timer, so the clear stays low
   ticap_timer u_first (
      .pclk(pclk),
      .presetn(presetn),
      .enable(first_on),
      .src_sel(count_source_select),
      .insn_tick(insn_tick),
      .ext_rise(ext_rise),
      .sync_clear(1'b0),
      .wr_en(t1cnt_wr),
      .wr_value(pwdata[15:0]),
      .count(first_timer_count)
   );

   ticap_timer u_second (
      .pclk(pclk),
      .presetn(presetn),
      .enable(second_on),
      .src_sel(second_timer_control_q[`TICAP_BIT_SRC_SEL]),
      .insn_tick(insn_tick),
      .ext_rise(ext_rise),
      .sync_clear(1'b0),
      .wr_en(t2cnt_wr),
      .wr_value(pwdata[15:0]),
      .count(second_timer_count)
   );

   // Capture source chosen in the second timer control
   assign cap_src = cap_from_second ?
      second_timer_count : first_timer_count;

   // Mode decode shared by the prescaler, the edge select and the flag
   assign cap_active = is_capture(capture_control_q[3:0]);
   assign ev_mode = ev_of(capture_control_q[3:0]);
   assign cap_edge = (ev_mode == TICAP_EV_FALL) ? cap_fall : cap_rise;

   // Mode rewrite while capturing may raise a false flag
   assign mode_change = capctl_wr && cap_active &&
      is_capture(new_ctl[3:0]) &&
      (new_ctl[3:0] != capture_control_q[3:0]);

   // Prescaler counter for the 4th and 16th edge modes
   // Only leaving capture clears it; a direct mode switch keeps the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_q <= 4'h0;
      end else if (!cap_active) begin
         prescale_q <= 4'h0;
      end else if (cap_edge) begin
         prescale_q <= prescale_q + 4'h1;
      end
   end

   // Prescaled modes fire on the edge that completes the count
   always_comb begin
      case (ev_mode)
         TICAP_EV_RISE4: cap_fire = cap_edge && (prescale_q[1:0] == 2'h3);
         TICAP_EV_RISE16: cap_fire = cap_edge && (prescale_q == 4'hF);
         default: cap_fire = cap_edge;
      endcase
      cap_fire = cap_fire && cap_active;
   end

   // Capture register, newest value wins
   // Nothing holds a capture off while the previous value is unread
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_value_pair_q <= `TICAP_RST_CNT;
      end else if (cap_fire) begin
         capture_value_pair_q <= cap_src;
      end
   end

   // Real captures and mode rewrites share one set path
   assign flag_set = cap_fire || mode_change;

   // Flag: hardware set wins over software clear, so no event is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peripheral_flags_a_q <= `TICAP_RST_CTL;
      end else begin
         if (hit(`TICAP_OFF_FLAGS)) peripheral_flags_a_q <= new_ctl;
         if (flag_set) begin
            peripheral_flags_a_q[`TICAP_BIT_CAP_FLAG] <= 1'b1;
         end
      end
   end

   assign capture_value_pair = capture_value_pair_q;
   assign capture_event_irq =
      peripheral_flags_a_q[`TICAP_BIT_CAP_FLAG] &&
      peripheral_irq_enables_a_q[`TICAP_BIT_CAP_FLAG];
   // The slave never stalls and never reports an error
   assign pslverr = 1'b0;

   // Oscillator pins read low while the oscillator owns them
   assign port_rd = {capture_pin_lvl,
      pin_lvl_q[1:0] & {2{!low_freq_osc_enable}}};

   // Read data chosen from the setup-cycle address
   always_comb begin
      case (paddr)
         `TICAP_OFF_T1CTL: rd_mux = {24'h0, first_timer_control_q};
         `TICAP_OFF_T2CTL: rd_mux = {24'h0, second_timer_control_q};
         `TICAP_OFF_CAPCTL: rd_mux = {24'h0, capture_control_q};
         `TICAP_OFF_FLAGS: rd_mux = {24'h0, peripheral_flags_a_q};
         `TICAP_OFF_IRQEN: rd_mux = {24'h0, peripheral_irq_enables_a_q};
         `TICAP_OFF_DIR: rd_mux = {24'h0, port_c_direction_q};
         `TICAP_OFF_PORTOUT: rd_mux = {24'h0, port_latch_q};
         `TICAP_OFF_PORTIN: rd_mux = {29'h0, port_rd};
         `TICAP_OFF_T1CNT: rd_mux = {16'h0, first_timer_count};
         `TICAP_OFF_T2CNT: rd_mux = {16'h0, second_timer_count};
         `TICAP_OFF_CAPVAL: rd_mux = {16'h0, capture_value_pair_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data registered in the setup cycle, held until the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_acc) begin
         prdata <= rd_mux;
      end
   end
endmodule

// file: rtl/ticap_regs.svh
// Register offsets, field positions and reset values of the timer capture block
`ifndef TICAP_REGS_SVH
`define TICAP_REGS_SVH

`define TICAP_OFF_T1CTL 12'h000
`define TICAP_OFF_T2CTL 12'h004
`define TICAP_OFF_CAPCTL 12'h008
`define TICAP_OFF_FLAGS 12'h00C
`define TICAP_OFF_IRQEN 12'h010
`define TICAP_OFF_DIR 12'h014
`define TICAP_OFF_PORTOUT 12'h018
`define TICAP_OFF_PORTIN 12'h01C
`define TICAP_OFF_T1CNT 12'h020
`define TICAP_OFF_T2CNT 12'h024
`define TICAP_OFF_CAPVAL 12'h028

`define TICAP_BIT_TMR_ON 0
`define TICAP_BIT_SRC_SEL 1
`define TICAP_BIT_OSC_EN 3
`define TICAP_BIT_CAP_TMR2 6
`define TICAP_BIT_CAP_FLAG 2
`define TICAP_BIT_CAP_PIN 2

`define TICAP_RST_CTL 8'h00
`define TICAP_RST_DIR 8'hFF
`define TICAP_RST_PORT 8'h00
`define TICAP_RST_CNT 16'h0000

`define TICAP_INSN_DIV 4
`endif

// file: rtl/ticap_pkg.sv
// Types shared by the timer capture block
package ticap_pkg;
   typedef enum logic [1:0] {
      TICAP_EV_FALL,
      TICAP_EV_RISE,
      TICAP_EV_RISE4,
      TICAP_EV_RISE16
   } ticap_event_t;
   typedef logic [15:0] ticap_count_t;
endpackage

// file: rtl/ticap_timer.sv
// Sixteen-bit timer with selectable count source and synchronous clear
`timescale 1ns/100ps
`include "ticap_regs.svh"
module ticap_timer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic enable,
   input wire logic src_sel,
   input wire logic insn_tick,
   input wire logic ext_rise,
   input wire logic sync_clear,
   input wire logic wr_en,
   input wire ticap_pkg::ticap_count_t wr_value,
   // Count
   output ticap_pkg::ticap_count_t count
);
   import ticap_pkg::*;
   ticap_count_t count_q;
   logic step;

   // Source selects instruction ticks or external rising edges
   assign step = enable && (src_sel ? ext_rise : insn_tick);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= `TICAP_RST_CNT;
      end else if (sync_clear) begin
         count_q <= `TICAP_RST_CNT;
      end else if (wr_en) begin
         count_q <= wr_value;
      end else if (step) begin
         count_q <= count_q + 16'h0001;
      end
   end

   assign count = count_q;
endmodule

// file: tb/ticap_top_props.sv
// Port checks for the timer capture block
`timescale 1ns/100ps
`include "ticap_regs.svh"
module ticap_props (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and status
   input wire logic [2:0] port_in,
   input wire logic [2:0] port_out,
   input wire logic [2:0] port_oe,
   input wire logic capture_event_irq,
   input wire ticap_pkg::ticap_count_t capture_value_pair
);
   import ticap_pkg::*;
   logic wr;
   logic [7:0] dir_q;
   logic [7:0] lat_q;
   logic osc_q;
   logic ien_q;
   logic pin_q;
   logic [3:0] age_q;
   assign wr = psel & penable & pwrite & pready;
   // Shadow copies of the writable bits the pins and the interrupt depend on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= 8'hFF;
         lat_q <= 8'h00;
         osc_q <= 1'b0;
         ien_q <= 1'b0;
      end else if (wr) begin
         if (paddr == `TICAP_OFF_DIR) dir_q <= pwdata[7:0];
         if (paddr == `TICAP_OFF_PORTOUT) lat_q <= pwdata[7:0];
         if (paddr == `TICAP_OFF_T1CTL) osc_q <= pwdata[3];
         if (paddr == `TICAP_OFF_IRQEN) ien_q <= pwdata[2];
      end
   end
   // Clocks since the capture pin last moved, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b0;
         age_q <= 4'h0;
      end else begin
         pin_q <= port_in[2];
         age_q <= (port_in[2] != pin_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_no_err: assert property (pready && !pslverr)
      else $error("bus answer not ready or error");
   a_oe_from_dir: assert property (
      port_oe == (osc_q ? {~dir_q[2], 2'b00} : ~dir_q[2:0]))
      else $error("pin enables do not follow direction");
   a_out_latch: assert property (port_out == lat_q[2:0])
      else $error("pin drive differs from latch");
   a_cap_after_edge: assert property (
      $changed(capture_value_pair) |-> age_q inside {[2:9]})
      else $error("capture value moved without a pin edge");
   a_irq_sticky: assert property ($fell(capture_event_irq) |->
      $past(wr) && $past(paddr) inside {`TICAP_OFF_FLAGS, `TICAP_OFF_IRQEN})
      else $error("capture flag cleared without a write");
   a_irq_gated: assert property (capture_event_irq |-> ien_q)
      else $error("interrupt raised while disabled");
   a_unmapped_zero: assert property (psel && !penable && !pwrite &&
      paddr == 12'h03C |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_dir_read: assert property (psel && !penable && !pwrite &&
      paddr == `TICAP_OFF_DIR |=> prdata[7:0] == dir_q)
      else $error("direction read differs");
endmodule
bind ticap_top ticap_props chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
   .capture_event_irq(capture_event_irq),
   .capture_value_pair(capture_value_pair));

// file: tb/ticap_pin_model.sv
// Outside signal source on the clock and capture pins
`timescale 1ns/100ps
module ticap_pin_model (
   // Clock
   input wire logic pclk,
   // Pin levels
   output logic [2:0] ext
);
   initial ext = 3'h0;
   // Levels held several clocks so the synchroniser sees each one
   task automatic pulse(input int idx, input int hold);
      @(posedge pclk);
      ext[idx] <= 1'b1;
      repeat (hold) @(posedge pclk);
      ext[idx] <= 1'b0;
      repeat (hold) @(posedge pclk);
   endtask
   task automatic pulses(input int idx, input int n);
      repeat (n) pulse(idx, 8);
   endtask
   task automatic level(input logic [2:0] v);
      ext <= v;
   endtask
endmodule

// file: tb/ticap_top_tb.sv
// Self-checking bench for the timer capture block
`timescale 1ns/100ps
`include "ticap_regs.svh"
module ticap_top_tb;
   import ticap_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d, e;
   logic [2:0] port_in, port_out, port_oe, ext;
   ticap_count_t cap;
   int errors, compares, cyc;
   int kk[4] = '{1, 1, 4, 16};
   initial pclk = 0;
   always #4 pclk = ~pclk;
   // A driven pin shows the device's own level
   assign port_in = (port_oe & port_out) | (~port_oe & ext);
   ticap_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
      .capture_event_irq(irq), .capture_value_pair(cap));
   ticap_pin_model pm (.pclk(pclk), .ext(ext));
   task automatic results;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         results();
      end
   end
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         errors++;
         $display("BAD %s exp %h got %h", n, x, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0);
      chk(n, x, d);
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      errors = 0;
      compares = 0;
      cyc = 0;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("oe", 32'h0, port_oe);
      rdc("dir", `TICAP_OFF_DIR, 32'hFF);
      rdc("gap", 12'h03C, 32'h0);
      xfer(1'b1, `TICAP_OFF_T1CTL, 32'h1);
      xfer(1'b0, `TICAP_OFF_T1CNT, 32'h0);
      e = d;
      repeat (37) @(posedge pclk);
      rdc("insn", `TICAP_OFF_T1CNT, e + 32'hA);
      xfer(1'b1, `TICAP_OFF_T1CTL, 32'h3);
      xfer(1'b1, `TICAP_OFF_T1CNT, 32'h0);
      pm.pulse(0, 20);
      pm.pulses(0, 4);
      rdc("ext", `TICAP_OFF_T1CNT, 32'h5);
      xfer(1'b1, `TICAP_OFF_T1CTL, 32'h0);
      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, `TICAP_OFF_IRQEN, 32'h0);
         xfer(1'b1, `TICAP_OFF_T1CNT, 32'h1230 + m);
         xfer(1'b1, `TICAP_OFF_FLAGS, 32'h0);
         xfer(1'b1, `TICAP_OFF_CAPCTL, 32'h4 + m);
         rdc("spur", `TICAP_OFF_FLAGS, (m > 0) ? 32'h4 : 32'h0);
         pm.pulses(2, 2);
         xfer(1'b1, `TICAP_OFF_CAPCTL, 32'h0);
         xfer(1'b1, `TICAP_OFF_CAPCTL, 32'h4 + m);
         xfer(1'b1, `TICAP_OFF_FLAGS, 32'h0);
         xfer(1'b1, `TICAP_OFF_IRQEN, 32'h4);
         pm.pulses(2, kk[m] - 1);
         rdc("early", `TICAP_OFF_FLAGS, 32'h0);
         pm.pulses(2, 1);
         chk("irq", 32'h1, irq);
         rdc("flag", `TICAP_OFF_FLAGS, 32'h4);
         chk("pair", 32'h1230 + m, cap);
         rdc("cap", `TICAP_OFF_CAPVAL, 32'h1230 + m);
      end
      xfer(1'b1, `TICAP_OFF_CAPCTL, 32'h0);
      xfer(1'b1, `TICAP_OFF_CAPCTL, 32'h5);
      xfer(1'b1, `TICAP_OFF_T2CTL, 32'h40);
      xfer(1'b1, `TICAP_OFF_T2CNT, 32'h5A5A);
      pm.pulses(2, 1);
      xfer(1'b1, `TICAP_OFF_T2CNT, 32'h0F0F);
      pm.pulses(2, 1);
      rdc("t2cap", `TICAP_OFF_CAPVAL, 32'h0F0F);
      xfer(1'b1, `TICAP_OFF_FLAGS, 32'h0);
      xfer(1'b1, `TICAP_OFF_DIR, 32'hFB);
      xfer(1'b1, `TICAP_OFF_PORTOUT, 32'h4);
      repeat (12) @(posedge pclk);
      rdc("outcap", `TICAP_OFF_FLAGS, 32'h4);
      pm.level(3'h3);
      xfer(1'b1, `TICAP_OFF_DIR, 32'hF8);
      xfer(1'b1, `TICAP_OFF_T1CTL, 32'h8);
      chk("oscoe", 32'h4, port_oe);
      rdc("oscin", `TICAP_OFF_PORTIN, 32'h4);
      results();
   end
endmodule
